// file: uhoc_mode_ctrl.v
// Contract
// - bits 31:9 read zero; software writes their reset value.
// - interrupt routing bit resets to zero.
// - routing zero sends interrupts to the vectored controller; one is invalid.
// - functional state field reports reset, resume, operational or suspend.
// - every functional state change yields a start-of-frame 1 ms later.
// - each start-of-frame sets a flag in the interrupt status register.
// - on switching to bulk, sample bulk enable; process bulk only if set.
// - on switching to control, sample control enable; process only if set.
// - bulk, control and isochronous enable writes take effect at next frame.
// - isochronous descriptor met: continue if enabled, else leave periodic list.
// - periodic enable gates periodic processing for the next frame.
// - compare control-served count with ratio before nonperiodic service.
// - ratio field value plus one control endpoints per bulk endpoint.
// - soft reset forces suspend, resets registers, ends within 10 us.
//
// operating-mode register bank with scheduler gating outputs
// assumes a single 40 MHz clock and the plain strobe register port
`timescale 1ns/1ps
`include "uhoc_defs.vh"
module uhoc_mode_ctrl #(
  parameter SOF_CYCLES  = `UHOC_SOF_CYCLES,
  parameter SRST_CYCLES = `UHOC_SRST_CYCLES
) (
  input  wire                 REF_CLK,
  input  wire                 RST_N,
  input  wire [`UHOC_AW-1:0]  ADDR,
  input  wire [31:0]          WDATA,
  input  wire                 WR,
  input  wire                 RD,
  output reg  [31:0]          RDATA,
  output reg                  IRQ_VECTORED,
  output reg                  SOF_PULSE,
  output reg  [1:0]           FUNCTIONAL_STATE,
  output reg  [1:0]           CONTROL_BULK_RATIO,
  output reg                  PERIODIC_LIST_ENABLE,
  output reg                  ISO_CONTINUE,
  output reg                  CONTROL_GO,
  output reg                  BULK_GO,
  output reg                  BULK_DUE,
  output reg                  SOFT_RESET_BUSY,
  input  wire                 SWITCH_TO_CONTROL,
  input  wire                 SWITCH_TO_BULK,
  input  wire                 ISO_DESC_SEEN,
  input  wire                 CONTROL_SERVED
);

  // ==========================================================
  // register state
  reg        route_sel;
  reg [1:0]  state;
  reg        bulk_en_sw;
  reg        ctrl_en_sw;
  reg        iso_en_sw;
  reg        per_en_sw;
  reg [1:0]  ratio;
  // frame-latched copies: the scheduler sees enables only from the next frame
  reg        bulk_en_fr;
  reg        ctrl_en_fr;
  reg        iso_en_fr;
  reg        per_en_fr;
  reg [`UHOC_IRQ_W-1:0] irq_stat;
  reg [`UHOC_IRQ_W-1:0] irq_mask;
  reg        srst_active;
  reg [`UHOC_SRST_W-1:0] srst_cnt;

  wire       sof_done;
  wire       ratio_due;
  wire [2:0] ratio_count;

  wire wr_mode = WR && (ADDR == `UHOC_ADDR_MODE);
  wire wr_cmd  = WR && (ADDR == `UHOC_ADDR_CMD);
  wire wr_stat = WR && (ADDR == `UHOC_ADDR_IRQ_STAT);
  wire wr_mask = WR && (ADDR == `UHOC_ADDR_IRQ_MASK);

  wire [1:0] new_state = WDATA[`UHOC_STATE_MSB:`UHOC_STATE_LSB];
  wire       state_change = (wr_mode && !srst_active && new_state != state) ||
                            (srst_active && state != `UHOC_FS_SUSPEND);

  wire [`UHOC_IRQ_W-1:0] irq_set;
  assign irq_set[`UHOC_IRQ_SOF_BIT]   = sof_done;
  // a one in the routing bit is flagged as a software fault
  assign irq_set[`UHOC_IRQ_ROUTE_BIT] = wr_mode && WDATA[`UHOC_ROUTE_BIT];

  // ==========================================================
  // start-of-frame after each state change
  uhoc_sof_timer #(
    .WIDTH (16),
    .LOAD  (SOF_CYCLES)
  ) u_sof (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .start (state_change),
    .done  (sof_done)
  );

  // ==========================================================
  // control/bulk service ratio
  uhoc_ratio_ctr u_ratio (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .ratio    (ratio),
    .served   (CONTROL_SERVED),
    .clear    (SWITCH_TO_BULK || srst_active),
    .bulk_due (ratio_due),
    .count    (ratio_count)
  );

  // ==========================================================
  // software-visible mode register and soft reset
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      route_sel   <= 1'b0;
      state       <= `UHOC_FS_RESET;
      bulk_en_sw  <= 1'b0;
      ctrl_en_sw  <= 1'b0;
      iso_en_sw   <= 1'b0;
      per_en_sw   <= 1'b0;
      ratio       <= 2'h0;
      srst_active <= 1'b0;
      srst_cnt    <= {`UHOC_SRST_W{1'b0}};
      irq_mask    <= {`UHOC_IRQ_W{1'b0}};
    end else if (srst_active) begin
      // operational registers held at reset values, state at suspend, for the soft reset span
      route_sel  <= 1'b0;
      state      <= `UHOC_FS_SUSPEND;
      bulk_en_sw <= 1'b0;
      ctrl_en_sw <= 1'b0;
      iso_en_sw  <= 1'b0;
      per_en_sw  <= 1'b0;
      ratio      <= 2'h0;
      irq_mask   <= {`UHOC_IRQ_W{1'b0}};
      if (srst_cnt == SRST_CYCLES[`UHOC_SRST_W-1:0] - {{(`UHOC_SRST_W-1){1'b0}}, 1'b1}) begin
        srst_active <= 1'b0;
        srst_cnt    <= {`UHOC_SRST_W{1'b0}};
      end else begin
        srst_cnt <= srst_cnt + {{(`UHOC_SRST_W-1){1'b0}}, 1'b1};
      end
    end else begin
      if (wr_cmd && WDATA[`UHOC_CMD_RESET_BIT])
        srst_active <= 1'b1;
      if (wr_mode) begin
        // routing one is invalid: hold zero so interrupts stay vectored
        route_sel  <= 1'b0;
        state      <= new_state;
        bulk_en_sw <= WDATA[`UHOC_BULK_BIT];
        ctrl_en_sw <= WDATA[`UHOC_CONTROL_BIT];
        iso_en_sw  <= WDATA[`UHOC_ISO_BIT];
        per_en_sw  <= WDATA[`UHOC_PERIODIC_BIT];
        ratio      <= WDATA[`UHOC_RATIO_MSB:`UHOC_RATIO_LSB];
      end
      if (wr_mask)
        irq_mask <= WDATA[`UHOC_IRQ_W-1:0];
    end
  end

  // ==========================================================
  // frame-boundary latching of list enables
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bulk_en_fr <= 1'b0;
      ctrl_en_fr <= 1'b0;
      iso_en_fr  <= 1'b0;
      per_en_fr  <= 1'b0;
    end else if (srst_active) begin
      bulk_en_fr <= 1'b0;
      ctrl_en_fr <= 1'b0;
      iso_en_fr  <= 1'b0;
      per_en_fr  <= 1'b0;
    end else if (sof_done) begin
      bulk_en_fr <= bulk_en_sw;
      ctrl_en_fr <= ctrl_en_sw;
      iso_en_fr  <= iso_en_sw;
      per_en_fr  <= per_en_sw;
    end
  end

  // ==========================================================
  // interrupt status: write one to clear, a new event wins
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat <= {`UHOC_IRQ_W{1'b0}};
    end else if (srst_active) begin
      irq_stat <= {`UHOC_IRQ_W{1'b0}};
    end else begin
      irq_stat <= (irq_stat & ~(wr_stat ? WDATA[`UHOC_IRQ_W-1:0] : {`UHOC_IRQ_W{1'b0}}))
                  | irq_set;
    end
  end

  // ==========================================================
  // scheduler outputs and read port
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_VECTORED         <= 1'b0;
      SOF_PULSE            <= 1'b0;
      FUNCTIONAL_STATE     <= `UHOC_FS_RESET;
      CONTROL_BULK_RATIO   <= 2'h0;
      PERIODIC_LIST_ENABLE <= 1'b0;
      ISO_CONTINUE         <= 1'b0;
      CONTROL_GO           <= 1'b0;
      BULK_GO              <= 1'b0;
      BULK_DUE             <= 1'b0;
      SOFT_RESET_BUSY      <= 1'b0;
      RDATA                <= 32'h0;
    end else begin
      // routing is always vectored, so only the mask gates the line
      IRQ_VECTORED         <= !route_sel && |(irq_stat & irq_mask);
      SOF_PULSE            <= sof_done;
      FUNCTIONAL_STATE     <= state;
      CONTROL_BULK_RATIO   <= ratio;
      PERIODIC_LIST_ENABLE <= per_en_fr;
      ISO_CONTINUE         <= ISO_DESC_SEEN && iso_en_fr;
      CONTROL_GO           <= SWITCH_TO_CONTROL && ctrl_en_fr;
      BULK_GO              <= SWITCH_TO_BULK && bulk_en_fr;
      BULK_DUE             <= ratio_due;
      SOFT_RESET_BUSY      <= srst_active;
      RDATA                <= 32'h0;
      if (RD) begin
        case (ADDR)
          `UHOC_ADDR_MODE:
            RDATA <= {23'h0, route_sel, state, bulk_en_sw, ctrl_en_sw,
                      iso_en_sw, per_en_sw, ratio};
          `UHOC_ADDR_CMD:
            RDATA <= {28'h0, ratio_count, srst_active};
          `UHOC_ADDR_IRQ_STAT:
            RDATA <= {30'h0, irq_stat};
          `UHOC_ADDR_IRQ_MASK:
            RDATA <= {30'h0, irq_mask};
          default:
            RDATA <= 32'h0;
        endcase
      end
    end
  end

endmodule // uhoc_mode_ctrl

// file: uhoc_defs.vh
// constants for the host operating-mode control block
// assumes a 40 MHz REF_CLK and a word-wide register port
`ifndef UHOC_DEFS_VH
`define UHOC_DEFS_VH

`define UHOC_AW             4
// register indices on the register port (word addresses)
`define UHOC_ADDR_MODE      4'h0
`define UHOC_ADDR_CMD       4'h1
`define UHOC_ADDR_IRQ_STAT  4'h2
`define UHOC_ADDR_IRQ_MASK  4'h3

// operating-mode field positions
`define UHOC_RATIO_LSB      0
`define UHOC_RATIO_MSB      1
`define UHOC_PERIODIC_BIT   2
`define UHOC_ISO_BIT        3
`define UHOC_CONTROL_BIT    4
`define UHOC_BULK_BIT       5
`define UHOC_STATE_LSB      6
`define UHOC_STATE_MSB      7
`define UHOC_ROUTE_BIT      8
`define UHOC_MODE_RESET     9'h000

// functional state encodings
`define UHOC_FS_RESET       2'h0
`define UHOC_FS_RESUME      2'h1
`define UHOC_FS_OPER        2'h2
`define UHOC_FS_SUSPEND     2'h3

// command register: soft reset command bit
`define UHOC_CMD_RESET_BIT  0
// interrupt status bits
`define UHOC_IRQ_SOF_BIT    0
`define UHOC_IRQ_ROUTE_BIT  1
`define UHOC_IRQ_W          2

// timing
`define UHOC_CLK_HZ         40000000
`define UHOC_SOF_DELAY_US   1000
`define UHOC_SOF_CYCLES     ((`UHOC_CLK_HZ / 1000000) * `UHOC_SOF_DELAY_US)
`define UHOC_SRST_MAX_US    10
`define UHOC_SRST_CYCLES    ((`UHOC_CLK_HZ / 1000000) * `UHOC_SRST_MAX_US)
`define UHOC_SRST_W         9

`endif

// file: uhoc_sof_timer.v
// one-shot timer: after a start pulse, counts LOAD cycles and then pulses done
// assumes a single clock; a restart while running reloads the count
`timescale 1ns/1ps
module uhoc_sof_timer #(
  parameter WIDTH = 16,
  parameter LOAD  = 40000
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             start,
  output reg              done
);
  reg [WIDTH-1:0] count;
  reg             running;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= {WIDTH{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= LOAD[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
        running <= 1'b1;
      end else if (running) begin
        if (count == {WIDTH{1'b0}}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // uhoc_sof_timer

// file: uhoc_ratio_ctr.v
// counts control endpoints served and tells the scheduler when bulk is due
// assumes served/bulk pulses are one cycle and never coincide with a clear
`timescale 1ns/1ps
module uhoc_ratio_ctr (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] ratio,
  input  wire       served,
  input  wire       clear,
  output wire       bulk_due,
  output reg  [2:0] count
);
  // ratio field holds served-count minus one
  assign bulk_due = (count > {1'b0, ratio});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 3'h0;
    end else if (clear) begin
      count <= 3'h0;
    end else if (served && count != 3'h7) begin
      count <= count + 3'h1;
    end
  end
endmodule // uhoc_ratio_ctr

// file: uhoc_mode_ctrl_chk.sv
// port checker for the operating-mode control block
// assumes its count parameters match the bound instance
`timescale 1ns/1ps
`include "uhoc_defs.vh"
module uhoc_mode_ctrl_chk #(
  parameter SOF_CYCLES  = 20,
  parameter SRST_CYCLES = 8
) (
  input wire        REF_CLK,
  input wire        RST_N,
  input wire [3:0]  ADDR,
  input wire        RD,
  input wire [31:0] RDATA,
  input wire        SOF_PULSE,
  input wire [1:0]  FUNCTIONAL_STATE,
  input wire        CONTROL_GO,
  input wire        BULK_GO,
  input wire        ISO_CONTINUE,
  input wire        BULK_DUE,
  input wire        SOFT_RESET_BUSY,
  input wire        SWITCH_TO_CONTROL,
  input wire        SWITCH_TO_BULK,
  input wire        ISO_DESC_SEEN,
  input wire        CONTROL_SERVED
);
  // slack around the frame delay covers the timer start and status lag
  localparam int SOF_LO  = SOF_CYCLES - 2;
  localparam int SOF_HI  = SOF_CYCLES + 6;
  localparam int SRST_HI = SRST_CYCLES + 3;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ====
  // assertions
  property p_rdata_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read slot");
  property p_mode_rsvd; $past(RD) && $past(ADDR) == `UHOC_ADDR_MODE |-> RDATA[31:8] == 24'h0;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd)
    else $error("mode upper bits not zero");
  property p_bulk_go; BULK_GO |-> $past(SWITCH_TO_BULK); endproperty
  a_bulk_go: assert property (p_bulk_go)
    else $error("bulk go without switch");
  property p_ctrl_go; CONTROL_GO |-> $past(SWITCH_TO_CONTROL); endproperty
  a_ctrl_go: assert property (p_ctrl_go)
    else $error("control go without switch");
  property p_iso; ISO_CONTINUE |-> $past(ISO_DESC_SEEN); endproperty
  a_iso: assert property (p_iso)
    else $error("iso continue without descriptor");
  property p_sof_after; $changed(FUNCTIONAL_STATE) |-> ##[SOF_LO:SOF_HI] SOF_PULSE; endproperty
  a_sof_after: assert property (p_sof_after)
    else $error("no frame start after state change");
  property p_sof_once; SOF_PULSE |=> !SOF_PULSE; endproperty
  a_sof_once: assert property (p_sof_once)
    else $error("frame start longer than one cycle");
  property p_srst_end; $rose(SOFT_RESET_BUSY) |-> ##[1:SRST_HI] !SOFT_RESET_BUSY; endproperty
  a_srst_end: assert property (p_srst_end)
    else $error("soft reset too long");
  property p_srst_st; SOFT_RESET_BUSY && $past(SOFT_RESET_BUSY) |-> FUNCTIONAL_STATE == 2'h3;
  endproperty
  a_srst_st: assert property (p_srst_st)
    else $error("soft reset not in suspend");
  property p_due_clr;
    $past(SWITCH_TO_BULK, 2) && !$past(CONTROL_SERVED) && !$past(CONTROL_SERVED, 2) |-> !BULK_DUE;
  endproperty
  a_due_clr: assert property (p_due_clr)
    else $error("bulk due after switch to bulk");
  c_sof: cover property (SOF_PULSE);
  c_bulk: cover property (BULK_GO);
  c_srst: cover property ($fell(SOFT_RESET_BUSY));
endmodule // uhoc_mode_ctrl_chk
bind uhoc_mode_ctrl uhoc_mode_ctrl_chk #(.SOF_CYCLES(SOF_CYCLES), .SRST_CYCLES(SRST_CYCLES)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
  .SOF_PULSE(SOF_PULSE), .FUNCTIONAL_STATE(FUNCTIONAL_STATE), .CONTROL_GO(CONTROL_GO),
  .BULK_GO(BULK_GO), .ISO_CONTINUE(ISO_CONTINUE), .BULK_DUE(BULK_DUE),
  .SOFT_RESET_BUSY(SOFT_RESET_BUSY), .SWITCH_TO_CONTROL(SWITCH_TO_CONTROL),
  .SWITCH_TO_BULK(SWITCH_TO_BULK), .ISO_DESC_SEEN(ISO_DESC_SEEN),
  .CONTROL_SERVED(CONTROL_SERVED));

// file: test_uhoc_mode_ctrl.sv
// self-checking bench for the operating-mode control block
// assumes shortened frame and soft reset counts set below
`timescale 1ns/1ps
`include "uhoc_defs.vh"
module test_uhoc_mode_ctrl;
  localparam SOF  = 20;
  localparam SRST = 8;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [3:0]  sw = 4'h0;
  wire [31:0] rdata;
  wire [1:0]  fs;
  wire [1:0]  ratio;
  wire        irq, sof, periodic_list_enable, iso_c, cgo, bgo, due, busy;
  wire [2:0]  go = {iso_c, bgo, cgo};
  integer     miscompares = 0;
  integer     compares = 0;
  integer     r, k;
  always #12.5 clk = ~clk;
  uhoc_mode_ctrl #(.SOF_CYCLES(SOF), .SRST_CYCLES(SRST)) dut (
    .REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ_VECTORED(irq), .SOF_PULSE(sof), .FUNCTIONAL_STATE(fs),
    .CONTROL_BULK_RATIO(ratio), .PERIODIC_LIST_ENABLE(periodic_list_enable), .ISO_CONTINUE(iso_c),
    .CONTROL_GO(cgo), .BULK_GO(bgo), .BULK_DUE(due), .SOFT_RESET_BUSY(busy),
    .SWITCH_TO_CONTROL(sw[0]), .SWITCH_TO_BULK(sw[1]), .ISO_DESC_SEEN(sw[2]),
    .CONTROL_SERVED(sw[3]));
  // ====
  // shared tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares = compares + 1;
    if (e !== s) begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a, input [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task pulse(input integer i);
    @(posedge clk);
    sw <= 4'h1 << i;
    @(posedge clk);
    sw <= 4'h0;
  endtask
  // go outputs answer one cycle after the scheduler pulse is taken
  task sched(input integer i, input logic e);
    pulse(i);
    #1 chk("go", e, go[i]);
  endtask
  task wait_on(input logic [1:0] sel, input integer lim);
    for (k = 0; k < lim && (sel[0] ? busy !== 1'b0 : sof !== 1'b1); k = k + 1) @(posedge clk) #1;
    if (k == lim) begin
      miscompares = miscompares + 1;
      final_report;
    end
  endtask
  // ====
  // scenarios
  task t_write;
    rd_reg(`UHOC_ADDR_MODE, 32'h0);
    rd_reg(4'h7, 32'h0);
    wr_reg(`UHOC_ADDR_MODE, 32'hffff_ffbf);
    rd_reg(`UHOC_ADDR_MODE, 32'h0000_00bf);
    wr_reg(`UHOC_ADDR_IRQ_MASK, 32'h3);
    rd_reg(`UHOC_ADDR_IRQ_STAT, 32'h2);
    chk("irq", 1'b1, irq);
    sched(1, 1'b0);
    wait_on(2'h0, SOF + 10);
    @(posedge clk) #1 chk("ple", 1'b1, periodic_list_enable);
    for (r = 0; r < 3; r = r + 1) sched(r, 1'b1);
    chk("state", 2'h2, fs);
    rd_reg(`UHOC_ADDR_IRQ_STAT, 32'h3);
    wr_reg(`UHOC_ADDR_IRQ_MASK, 32'h0);
    rd_reg(`UHOC_ADDR_IRQ_STAT, 32'h3);
    chk("irq", 1'b0, irq);
    wr_reg(`UHOC_ADDR_IRQ_STAT, 32'h3);
    rd_reg(`UHOC_ADDR_IRQ_STAT, 32'h0);
  endtask
  // enables written off here stay in force until the next frame start
  task t_ratio;
    for (r = 0; r < 4; r = r + 1) begin
      // lists are only touched by software while these enables are written off
      wr_reg(`UHOC_ADDR_MODE, 32'h80 | r);
      sched(1, 1'b1);
      for (k = 0; k < r; k = k + 1) pulse(3);
      repeat (2) @(posedge clk);
      #1 chk("due", 1'b0, due);
      pulse(3);
      repeat (2) @(posedge clk);
      #1 chk("due", 1'b1, due);
      chk("ratio", r, ratio);
      rd_reg(`UHOC_ADDR_CMD, (r + 1) << 1);
    end
    pulse(1);
    rd_reg(`UHOC_ADDR_CMD, 32'h0);
  endtask
  task t_srst;
    wr_reg(`UHOC_ADDR_CMD, 32'h1);
    rd_reg(`UHOC_ADDR_CMD, 32'h1);
    wait_on(2'h1, SRST + 5);
    rd_reg(`UHOC_ADDR_MODE, 32'hc0);
    wait_on(2'h0, SOF + 10);
    @(posedge clk) #1 chk("ple", 1'b0, periodic_list_enable);
    sched(1, 1'b0);
    sched(0, 1'b0);
    rd_reg(`UHOC_ADDR_IRQ_MASK, 32'h0);
    // resume is a state code no other scenario writes; the others write only operational
    wr_reg(`UHOC_ADDR_MODE, 32'h40);
    rd_reg(`UHOC_ADDR_MODE, 32'h40);
    wait_on(2'h0, SOF + 10);
    chk("state", 2'h1, fs);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // host power is taken as on from reset release; no access comes earlier
    t_write;
    t_ratio;
    t_srst;
    final_report;
  end
endmodule // test_uhoc_mode_ctrl
